// [sas_sequencer.sv]
// Converter sequencer: starts, timing, selection hold and results
// Contract
// - Convert the selected input by successive approximation to 10 bits.
// - Input field picks single ended or differential pair, gain 8x or 20x.
// - Selections written while disabled stay unapplied until enable is set.
// - Result right aligned by default, left aligned when left adjust set.
// - Low byte read blocks result updates until high byte is read.
// - Done flag still rises when a blocked result is discarded.
// - Start write begins conversion; start bit high while busy.
// - Channel change during conversion waits until that conversion ends.
// - Auto trigger edge on selected source resets prescaler and starts.
// - Trigger high at completion or edges during conversion start nothing.
// - Trigger flags set regardless; software clears them before next edge.
// - Own done flag as source means free running after first start.
// - Start write still starts a single conversion with auto trigger on another source.
// - Prescaler divides per select, counts only while enabled.
// - Start bit conversion begins at next converter clock rising edge.
// - Normal conversion 13 converter cycles, first after enable 25.
// - Hold at 1.5 cycles normal, 13.5 cycles on the first.
// - Completion writes result, sets flag, clears start bit if single.
// - Auto triggered: hold at 2 cycles, 13.5 total, 3 sync clocks.
// - Free running restarts at once, start bit stays high.
// - Selection hold tracks until start, frozen, tracks in last cycle.
module sas_sequencer
#(
   parameter int TSEL_W = 3,
   parameter int DONE_SRC = 0
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic converter_enable_bit,
   input wire logic start_write,
   input wire logic auto_trigger_enable,
   input wire logic [TSEL_W-1:0] trigger_source_select,
   input wire logic [(1<<TSEL_W)-1:0] trigger_sources,
   input wire logic left_adjust_select,
   input wire logic [2:0] prescaler_select,
   input wire sas_pkg::sas_sel_type sw_sel,
   input wire logic done_clear,
   input wire logic low_read,
   input wire logic high_read,
   input wire logic comp_in,
   output logic start_conversion_bit,
   output logic conversion_done_flag,
   output logic [7:0] result_high_byte,
   output logic [7:0] result_low_byte,
   output sas_pkg::sas_sel_type applied_sel,
   output logic gain_bypass,
   output logic gain_20x,
   output logic analog_enable,
   output logic hold_strobe,
   output logic [sas_pkg::RES_BITS-1:0] dac_code
);
   import sas_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   localparam int TRIG_N = 1 << TSEL_W;

   if (DONE_SRC < 0 || DONE_SRC >= TRIG_N || TSEL_W < 1)
   begin : g_chk
      $error("sas_sequencer trigger parameters out of range");
   end

   sas_state_type state;
   sas_state_type next_state;
   logic [4:0] cyc;
   logic [1:0] sync_cnt;
   logic mode_first;
   logic mode_auto;
   logic first_due;
   logic trig_prev;
   logic locked;
   logic [RES_BITS-1:0] raw;
   logic sar_running;
   logic tick_rise;
   logic tick_fall;
   logic [TRIG_N-1:0] trig_vec;

   // Own done flag stands in at its source slot
   for (genvar i = 0; i < TRIG_N; i++)
   begin : g_trig
      if (i == DONE_SRC)
      begin : g_own
         assign trig_vec[i] = conversion_done_flag;
      end
      else
      begin : g_ext
         assign trig_vec[i] = trigger_sources[i];
      end
   end

   // Trigger and mode decode
   wire logic en = converter_enable_bit;
   wire logic free_run = auto_trigger_enable &&
      (trigger_source_select == TSEL_W'(DONE_SRC));
   wire logic trig_lvl = trig_vec[trigger_source_select];
   wire logic trig_edge = trig_lvl && !trig_prev;
   // Edges only count while idle, so busy edges are lost
   wire logic trig_start = clk_en && en && auto_trigger_enable &&
      !free_run && trig_edge && (state == ST_IDLE);
   wire logic sw_start = clk_en && en && start_write &&
      (state == ST_IDLE);
   wire logic sync_done = (state == ST_SYNC) &&
      (sync_cnt == 2'(TRIG_SYNC_CYCLES - 2));
   wire logic presc_run = en && !(clk_en && sync_done);

   // Event points by mode; the first conversion wins over auto
   wire logic [4:0] sh_cyc = mode_first ? SH_FIRST :
      (mode_auto ? SH_AUTO : SH_NORMAL);
   wire logic [4:0] end_cyc = mode_first ? END_FIRST :
      (mode_auto ? END_AUTO : END_NORMAL);
   wire logic sh_on_rise = mode_auto && !mode_first;
   wire logic conv = (state == ST_CONV);
   wire logic sh_tick = sh_on_rise ? tick_rise : tick_fall;
   wire logic end_tick = sh_on_rise ? tick_fall : tick_rise;
   wire logic sample = clk_en && conv && sh_tick &&
      (cyc == sh_cyc);
   wire logic conv_end = clk_en && conv && end_tick &&
      (cyc == end_cyc);
   wire logic sar_step = conv && tick_rise;
   wire logic restart = conv_end && free_run;
   wire logic take_result = conv_end && !locked;

   // Hold register follows software only outside the locked window
   wire logic track = en && (!conv || (cyc == end_cyc));
   wire logic sel_se = (applied_sel.mux < SE_CHANNELS);

   // Result alignment, reserved bits zero
   wire logic [7:0] next_high = left_adjust_select ? raw[9:2] :
      {6'h00, raw[9:8]};
   wire logic [7:0] next_low = left_adjust_select ? {raw[1:0], 6'h00} :
      raw[7:0];

   // Next state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (sw_start)
            begin
               next_state = ST_WAIT;
            end
            else if (trig_start)
            begin
               next_state = ST_SYNC;
            end
         end
         ST_WAIT:
            if (tick_rise)
               next_state = ST_CONV;
         ST_SYNC:
            if (sync_done)
               next_state = ST_CONV;
         ST_CONV:
            if (conv_end && !free_run)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
      // Disable aborts from any state
      if (!en)
         next_state = ST_IDLE;
   end

   // Sequencer state and cycle count
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         cyc <= CYC_RESET;
         sync_cnt <= 2'h0;
         mode_auto <= 1'b0;
         mode_first <= 1'b0;
         start_conversion_bit <= 1'b0;
      end
      else if (clk_en)
      begin
         state <= next_state;
         start_conversion_bit <= (next_state != ST_IDLE);
         sync_cnt <= (state == ST_SYNC) ? sync_cnt + 2'h1 : 2'h0;
         if (state != ST_CONV || restart)
         begin
            cyc <= CYC_RESET;
            mode_auto <= (state == ST_SYNC);
            mode_first <= first_due && !restart;
         end
         else if (tick_rise)
         begin
            cyc <= cyc + 5'h01;
         end
      end
   end

   // First conversion after enable, trigger edge history
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         first_due <= 1'b1;
         trig_prev <= 1'b0;
         analog_enable <= 1'b0;
      end
      else if (clk_en)
      begin
         first_due <= !en || (first_due && !conv_end);
         trig_prev <= trig_lvl;
         analog_enable <= en;
      end
   end

   // Done flag: completion wins over a same-cycle clear
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         conversion_done_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         conversion_done_flag <= conv_end ||
            (conversion_done_flag && !done_clear);
      end
   end

   // Byte lock: low read closes, high read reopens
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         locked <= 1'b0;
      end
      else if (clk_en)
      begin
         locked <= !high_read && (low_read || locked);
      end
   end

   // Raw result and presented bytes
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         raw <= RESULT_RESET;
         result_high_byte <= BYTE_RESET;
         result_low_byte <= BYTE_RESET;
      end
      else if (clk_en)
      begin
         if (take_result)
         begin
            raw <= dac_code;
         end
         result_high_byte <= next_high;
         result_low_byte <= next_low;
      end
   end

   // Applied selection and gain path, hold strobe to the analog side
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         applied_sel <= SEL_RESET;
         gain_bypass <= 1'b1;
         gain_20x <= 1'b0;
         hold_strobe <= 1'b0;
      end
      else if (clk_en)
      begin
         if (track)
         begin
            applied_sel <= sw_sel;
         end
         gain_bypass <= sel_se;
         gain_20x <= !sel_se && applied_sel.mux[0];
         hold_strobe <= sample;
      end
   end

   sas_prescaler u_presc
   (
      .mclk(mclk),
      .nrst(nrst),
      .ce(clk_en),
      .run(presc_run),
      .sel(prescaler_select),
      .rise(tick_rise),
      .fall(tick_fall)
   );

   sas_sar #(.W(RES_BITS)) u_sar
   (
      .mclk(mclk),
      .nrst(nrst),
      .ce(clk_en),
      .abort(!en),
      .sample(sample),
      .step(sar_step),
      .comp_in(comp_in),
      .dac_code(dac_code),
      .running(sar_running)
   );

   done_raise_a: assert property (conv_end |=> conversion_done_flag)
      else $error("done flag not raised at completion");
   lock_keep_a: assert property ((conv_end && locked) |=>
      $stable(raw)) else $error("blocked result was written");
   result_take_a: assert property (take_result |=>
      raw == $past(dac_code)) else $error("result not stored");
   single_clear_a: assert property ((conv_end && !free_run && en)
      |=> !start_conversion_bit) else $error("start bit not cleared");
   free_again_a: assert property ((restart && en) |=>
      start_conversion_bit && conv && cyc == CYC_RESET)
      else $error("free running did not restart");
   busy_bit_a: assert property ((conv && en && !conv_end && clk_en)
      |=> start_conversion_bit) else $error("start bit low while busy");
   sel_freeze_a: assert property ((clk_en && !track) |=>
      $stable(applied_sel)) else $error("selection moved while locked");
   trig_sync_a: assert property ((trig_start && en) ##1
      (clk_en && en) [*2] |=> conv && mode_auto)
      else $error("trigger did not start after three clocks");
   wait_edge_a: assert property ((state == ST_WAIT && !tick_rise &&
      en && clk_en) |=> state == ST_WAIT)
      else $error("start ran ahead of converter edge");
endmodule // sas_sequencer

// [sas_pkg.sv]
// Shared constants and types of the converter sequencer
package sas_pkg;
   // Result width of the successive approximation
   localparam int RES_BITS = 10;
   // Trigger synchronisation delay in CPU clock cycles
   localparam int TRIG_SYNC_CYCLES = 3;
   // Event points, as the converter cycle count at the tick
   // Normal: hold on falling edge of cycle 1 (1.5)
   localparam logic [4:0] SH_NORMAL = 5'h01;
   // Normal: done at the 13th rising edge
   localparam logic [4:0] END_NORMAL = 5'h0C;
   // First: hold on falling edge of cycle 13 (13.5)
   localparam logic [4:0] SH_FIRST = 5'h0D;
   // First: done at the 25th rising edge
   localparam logic [4:0] END_FIRST = 5'h18;
   // Auto: hold on rising edge 2 after the trigger
   localparam logic [4:0] SH_AUTO = 5'h01;
   // Auto: done on falling edge of cycle 13 (13.5)
   localparam logic [4:0] END_AUTO = 5'h0D;
   // Input codes below this are single ended
   localparam logic [4:0] SE_CHANNELS = 5'h0B;
   // Reset values
   localparam logic [4:0] CYC_RESET = 5'h00;
   localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Sequencer states, Gray along both start paths
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_CONV = 2'b11,
      ST_SYNC = 2'b10
   } sas_state_type;

   // Reference and channel selection travel together
   typedef struct packed {
      logic [1:0] refsel;
      logic [4:0] mux;
   } sas_sel_type;

   localparam sas_sel_type SEL_RESET = 7'h00;

   // Division ratio: 2,2,4,8,...,128
   function automatic logic [7:0] sas_div(input logic [2:0] sel);
      logic [7:0] d;
      d = 8'h01 << sel;
      if (sel == 3'h0)
      begin
         d = 8'h02;
      end
      return d;
   endfunction
endpackage // sas_pkg

// [sas_prescaler.sv]
// Converter clock prescaler giving rising and falling ticks
module sas_prescaler
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic rise,
   output logic fall
);
   import sas_pkg::*;

   logic [7:0] cnt;
   wire logic [7:0] div = sas_div(sel);
   // At or past the top, so a smaller ratio in mid count cannot wrap
   wire logic at_top = (cnt >= div - 8'h01);
   wire logic at_half = (cnt == (div >> 1) - 8'h01);
   wire logic [7:0] next_cnt = at_top ? 8'h00 : cnt + 8'h01;

   // Counter held at zero while not running
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt <= 8'h00;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else if (ce)
      begin
         cnt <= run ? next_cnt : 8'h00;
         rise <= run && at_top;
         fall <= run && at_half;
      end
   end

   // Held prescaler gives no ticks
   held_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
      (!run && ce) |=> (cnt == 8'h00) && !rise && !fall)
      else $error("prescaler ran while held");
endmodule // sas_prescaler

// [sas_sar.sv]
// Successive approximation trial register
module sas_sar
#(
   parameter int W = 10
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic abort,
   input wire logic sample,
   input wire logic step,
   input wire logic comp_in,
   output logic [W-1:0] dac_code,
   output logic running
);
   if (W < 2)
   begin : g_chk
      $error("sas_sar width too small");
   end

   logic [W-1:0] mask;
   wire logic [W-1:0] top = {1'b1, {(W-1){1'b0}}};
   // Keep the trial bit when the input is at or above the DAC
   wire logic [W-1:0] kept = comp_in ? dac_code : (dac_code & ~mask);
   wire logic [W-1:0] next_code = kept | (mask >> 1);

   // Sample loads the midscale trial; each step resolves one bit
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         dac_code <= '0;
         mask <= '0;
         running <= 1'b0;
      end
      else if (ce)
      begin
         if (abort)
         begin
            mask <= '0;
            running <= 1'b0;
         end
         else if (sample)
         begin
            dac_code <= top;
            mask <= top;
            running <= 1'b1;
         end
         else if (step && running)
         begin
            dac_code <= next_code;
            mask <= mask >> 1;
            running <= (mask != {{(W-1){1'b0}}, 1'b1});
         end
      end
   end

   sar_load_a: assert property (@(posedge mclk) disable iff (!nrst)
      (sample && ce && !abort) |=> (dac_code == top) && running)
      else $error("sample did not load midscale trial");
endmodule // sas_sar

// [sas_sequencer_tb.sv]
// Self-checking bench of the converter sequencer
`define CHK(g, e, m) check((g) === (e), m)
module sas_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sas_pkg::*;

   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic en = 1'b0;
   logic sw = 1'b0;
   logic ate = 1'b0;
   logic lad = 1'b0;
   logic dclr = 1'b0;
   logic lrd = 1'b0;
   logic hrd = 1'b0;
   logic [2:0] tsel = 3'h0;
   logic [2:0] psel = 3'h0;
   logic [7:0] trig = 8'h00;
   sas_sel_type sel = SEL_RESET;
   logic [9:0] ain = 10'h000;
   logic sbit, flag, gbyp, g20, aen, hs;
   logic [7:0] hb, lb;
   sas_sel_type asel;
   logic [9:0] dac;
   wire comp;
   int err_total = 0;
   int num_checks = 0;
   int n, holds;

   // Ideal comparator: the analog input is simply the value ain
   assign comp = (ain >= dac);

   // 20 MHz clock
   always #25 mclk = ~mclk;

   sas_sequencer dut
   (
      .mclk(mclk), .nrst(nrst), .clk_en(clk_en),
      .converter_enable_bit(en), .start_write(sw),
      .auto_trigger_enable(ate), .trigger_source_select(tsel),
      .trigger_sources(trig), .left_adjust_select(lad),
      .prescaler_select(psel), .sw_sel(sel), .done_clear(dclr),
      .low_read(lrd), .high_read(hrd), .comp_in(comp),
      .start_conversion_bit(sbit), .conversion_done_flag(flag),
      .result_high_byte(hb), .result_low_byte(lb),
      .applied_sel(asel), .gain_bypass(gbyp), .gain_20x(g20),
      .analog_enable(aen), .hold_strobe(hs), .dac_code(dac)
   );

   task automatic check(input bit ok, input string m);
      num_checks++;
      if (!ok)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Inputs always move 2 ns after the rising edge
   task automatic tick;
      @(posedge mclk);
      #2;
   endtask

   task automatic pulse_start;
      sw = 1'b1;
      dclr = 1'b1;
      tick;
      sw = 1'b0;
      dclr = 1'b0;
      `CHK(sbit, 1'b1, "start bit not set");
   endtask

   // Bounded wait for the done flag; h < 0 skips the hold count
   task automatic wait_done(input int lo, input int hi, input int h);
      n = 0;
      holds = 0;
      while (flag !== 1'b1)
      begin
         if (hs === 1'b1)
            holds++;
         tick;
         n++;
         if (n > hi + 8)
         begin
            check(1'b0, "done flag timeout");
            summarize;
         end
      end
      check(n >= lo && n <= hi, "conversion length");
      if (h >= 0)
         check(holds == h, "hold strobe count");
   endtask

   task automatic exp_bytes(input logic [9:0] r, input logic l);
      if (l)
      begin
         `CHK(hb, r[9:2], "left high byte");
         `CHK(lb, {r[1:0], 6'h00}, "left low byte");
      end
      else
      begin
         `CHK(hb, {6'h00, r[9:8]}, "right high byte");
         `CHK(lb, r[7:0], "right low byte");
      end
   endtask

   initial
   begin
      repeat (4) tick;
      `CHK(sbit, 1'b0, "reset start bit");
      `CHK(gbyp, 1'b1, "reset bypass");
      nrst = 1'b1;
      // First conversion after enable, right aligned
      en = 1'b1;
      sel.mux = 5'h03;
      ain = 10'h2A5;
      repeat (3) tick;
      `CHK(asel.mux, 5'h03, "selection applied");
      pulse_start;
      wait_done(48, 54, 1);
      `CHK(sbit, 1'b0, "start bit cleared");
      `CHK(dac, 10'h2A5, "final trial code");
      tick;
      exp_bytes(10'h2A5, 1'b0);
      $display("test first conversion finished");
      // Normal conversion, left aligned
      lad = 1'b1;
      ain = 10'h15B;
      pulse_start;
      wait_done(24, 30, 1);
      tick;
      exp_bytes(10'h15B, 1'b1);
      $display("test left adjust finished");
      // Low byte read locks the result until the high byte read
      lrd = 1'b1;
      tick;
      lrd = 1'b0;
      ain = 10'h0F0;
      pulse_start;
      wait_done(24, 30, 1);
      tick;
      exp_bytes(10'h15B, 1'b1);
      hrd = 1'b1;
      tick;
      hrd = 1'b0;
      pulse_start;
      wait_done(24, 30, 1);
      tick;
      exp_bytes(10'h0F0, 1'b1);
      $display("test result lock finished");
      // Channel change in mid conversion waits for completion
      pulse_start;
      repeat (6) tick;
      sel.mux = 5'h05;
      repeat (4) tick;
      `CHK(asel.mux, 5'h03, "selection frozen");
      wait_done(10, 20, -1);
      tick;
      `CHK(asel.mux, 5'h05, "new selection");
      $display("test channel change finished");
      // Disabled converter holds selection writes back until enable is set
      en = 1'b0;
      sel.mux = 5'h07;
      sel.refsel = 2'h2;
      repeat (3) tick;
      `CHK(asel.mux, 5'h05, "selection while off");
      `CHK(asel.refsel, 2'h0, "reference while off");
      `CHK(aen, 1'b0, "analog off");
      en = 1'b1;
      repeat (3) tick;
      `CHK(asel.mux, 5'h07, "selection after enable");
      `CHK(asel.refsel, 2'h2, "reference after enable");
      `CHK(aen, 1'b1, "analog on");
      // Single ended limit and gain choice around the boundary
      for (int i = 10; i < 14; i++)
      begin
         sel.mux = 5'(i);
         repeat (3) tick;
         `CHK(gbyp, 1'(i < 11), "gain bypass");
         `CHK(g20, 1'(i >= 11 && i % 2 == 1), "gain 20x");
      end
      sel.mux = 5'h03;
      repeat (3) tick;
      pulse_start;
      wait_done(48, 54, 1);
      $display("test enable and gain finished");
      // Divide by 8
      psel = 3'h3;
      pulse_start;
      wait_done(105, 112, 1);
      // Slowest ratio keeps the converter clock near 156 kHz
      psel = 3'h7;
      pulse_start;
      wait_done(1665, 1792, 1);
      psel = 3'h0;
      $display("test prescaler finished");
      // Start write with auto trigger on and a quiet trigger
      ate = 1'b1;
      tsel = 3'h1;
      pulse_start;
      wait_done(24, 30, 1);
      `CHK(sbit, 1'b0, "single start cleared");
      // Trigger edge, then a second edge inside the conversion
      dclr = 1'b1;
      trig[1] = 1'b1;
      tick;
      dclr = 1'b0;
      repeat (8) tick;
      `CHK(sbit, 1'b1, "triggered start");
      trig[1] = 1'b0;
      tick;
      trig[1] = 1'b1;
      wait_done(14, 22, -1);
      for (int i = 0; i < 40; i++)
      begin
         tick;
         `CHK(sbit, 1'b0, "no retrigger");
      end
      // Software clears the trigger flag before the next event
      trig[1] = 1'b0;
      $display("test auto trigger finished");
      // Own done flag as source: free running
      tsel = 3'h0;
      pulse_start;
      wait_done(24, 30, 1);
      `CHK(sbit, 1'b1, "start bit held");
      dclr = 1'b1;
      tick;
      dclr = 1'b0;
      // Clock enable low freezes the running conversion, so it ends late
      clk_en = 1'b0;
      repeat (30) tick;
      clk_en = 1'b1;
      wait_done(20, 30, 1);
      `CHK(sbit, 1'b1, "still running");
      en = 1'b0;
      repeat (2) tick;
      `CHK(sbit, 1'b0, "abort on disable");
      ate = 1'b0;
      $display("test free running finished");
      summarize;
   end
endmodule // sas_sequencer_tb
